// ### adc_pwr_pkg.sv
package adc_pwr_pkg;
   localparam int unsigned CLK_HZ = 25000000;
   localparam int unsigned WAKE_US = 100;
   localparam int unsigned WAKE_CYC = WAKE_US * (CLK_HZ / 1000000);
   localparam int unsigned STBY_CYC = 200;
   localparam int unsigned NCH = 4;
   localparam int unsigned MIN_RATE_HZ = 1000000;
   localparam int unsigned STOP_CYC = CLK_HZ / MIN_RATE_HZ;
   localparam int unsigned MIN_AMP_MV = 400;
   // register byte addresses
   localparam logic [3:0] ADR_CTRL = 4'h0;
   localparam logic [3:0] ADR_GAIN = 4'h4;
   localparam logic [3:0] ADR_STAT = 4'h8;
   // control fields
   localparam int unsigned CTRL_PDN = 0;
   localparam int unsigned CTRL_REF = 1;
   localparam int unsigned CTRL_STBY = 4;
   // gain fields
   localparam int unsigned GAIN_FINE = 0;
   localparam int unsigned GAIN_COARSE = 4;
   localparam int unsigned GAIN_CLK = 8;
   localparam logic [2:0] FINE_MAX = 3'h6;
   localparam logic [2:0] FINE_RST = 3'h0;
   localparam logic [2:0] CLKG_MAX = 3'h4;
   localparam logic [2:0] CLKG_RST = 3'h1;
   // status fields
   localparam int unsigned ST_VALID = 0;
   localparam int unsigned ST_STOP = 4;
   localparam int unsigned ST_AWAKE = 5;
   localparam logic [1:0] ST_SYNC_W = 2'h2;
   typedef enum logic [1:0] {
      PS_OFF = 2'b00,
      PS_WAKE = 2'b01,
      PS_RUN = 2'b10
   } pwr_state_e;
endpackage

// ### adc_power_and_gain_control.sv
// Design decisions made here: the address map and the Wishbone interface to the registers.
`timescale 1ns/10ps
module adc_power_and_gain_control #(
   parameter int unsigned WAKE_CYCLES = adc_pwr_pkg::WAKE_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [31:0] adr_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   input wire logic we_i,
   input wire logic [3:0] sel_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   output logic ack_o,
   input wire logic samp_clk_i,
   input wire logic [15:0] clk_amp_mv_i,
   output logic [3:0] conv_pwr_o,
   output logic ref_pwr_o,
   output logic pll_pwr_o,
   output logic lvds_pwr_o,
   output logic lvds_oe_n_o,
   output logic [3:0] data_valid_o,
   output logic ref_internal_o,
   output logic cm_pin_oe_n_o,
   output logic [2:0] fine_gain_o,
   output logic coarse_gain_o,
   output logic [2:0] clock_buffer_gain_field_o
);
   localparam int unsigned N = adc_pwr_pkg::NCH;
   localparam logic [31:0] WAKE_MAX = 32'(WAKE_CYCLES);
   localparam logic [7:0] STBY_MAX = 8'(adc_pwr_pkg::STBY_CYC);
   localparam logic [7:0] STOP_MAX = 8'(adc_pwr_pkg::STOP_CYC);
   localparam logic [15:0] AMP_MIN = 16'(adc_pwr_pkg::MIN_AMP_MV);

   function automatic logic [2:0] clip3(input logic [2:0] v,
                                        input logic [2:0] mx);
      clip3 = (v > mx) ? mx : v;
   endfunction

   // register state
   logic chip_power_down_bit_q, chip_power_down_bit_d;
   logic ref_ext_q, ref_ext_d;
   logic [3:0] channel_standby_bits_q, channel_standby_bits_d;
   logic [2:0] fine_q, fine_d;
   logic coarse_q, coarse_d;
   logic [2:0] clkg_q, clkg_d;
   logic ack_q, ack_d;
   logic [31:0] rdat_q, rdat_d;
   // power state
   logic [2:0] samp_sync_q, samp_sync_d;
   logic [7:0] stop_cnt_q, stop_cnt_d;
   logic stop_q, stop_d;
   adc_pwr_pkg::pwr_state_e ps_q, ps_d;
   logic [31:0] wake_q, wake_d;
   logic [7:0] stby_cnt_q [N];
   logic [7:0] stby_cnt_d [N];
   logic [3:0] valid_q, valid_d;
   logic [3:0] conv_q, conv_d;
   logic pwr_q, pwr_d;
   logic lvds_q, lvds_d;
   logic oe_n_q, oe_n_d, ref_int_q, ref_int_d, cm_oe_n_q, cm_oe_n_d;

   wire logic req = cyc_i && stb_i && !ack_q;
   wire logic amp_low = (clkg_q == adc_pwr_pkg::CLKG_RST) &&
                        (clk_amp_mv_i < AMP_MIN);

   // register bus
   always_comb
   begin
      chip_power_down_bit_d = chip_power_down_bit_q;
      ref_ext_d = ref_ext_q;
      channel_standby_bits_d = channel_standby_bits_q;
      fine_d = fine_q;
      coarse_d = coarse_q;
      clkg_d = clkg_q;
      ack_d = req;
      rdat_d = rdat_q;
      if (req && we_i && sel_i[0])
      begin
         case (adr_i[3:0])
            adc_pwr_pkg::ADR_CTRL:
            begin
               chip_power_down_bit_d = dat_i[adc_pwr_pkg::CTRL_PDN];
               ref_ext_d = dat_i[adc_pwr_pkg::CTRL_REF];
               channel_standby_bits_d =
                  dat_i[adc_pwr_pkg::CTRL_STBY +: 4];
            end
            adc_pwr_pkg::ADR_GAIN:
            begin
               fine_d = clip3(dat_i[adc_pwr_pkg::GAIN_FINE +: 3],
                              adc_pwr_pkg::FINE_MAX);
               coarse_d = dat_i[adc_pwr_pkg::GAIN_COARSE];
            end
            default:
            begin
            end
         endcase
      end
      if (req && we_i && sel_i[1] && adr_i[3:0] == adc_pwr_pkg::ADR_GAIN)
      begin
         clkg_d = clip3(dat_i[adc_pwr_pkg::GAIN_CLK +: 3],
                        adc_pwr_pkg::CLKG_MAX);
      end
      if (req && !we_i)
      begin
         rdat_d = '0;
         case (adr_i[3:0])
            adc_pwr_pkg::ADR_CTRL:
            begin
               rdat_d[adc_pwr_pkg::CTRL_PDN] = chip_power_down_bit_q;
               rdat_d[adc_pwr_pkg::CTRL_REF] = ref_ext_q;
               rdat_d[adc_pwr_pkg::CTRL_STBY +: 4] = channel_standby_bits_q;
            end
            adc_pwr_pkg::ADR_GAIN:
            begin
               rdat_d[adc_pwr_pkg::GAIN_FINE +: 3] = fine_q;
               rdat_d[adc_pwr_pkg::GAIN_COARSE] = coarse_q;
               rdat_d[adc_pwr_pkg::GAIN_CLK +: 3] = clkg_q;
            end
            adc_pwr_pkg::ADR_STAT:
            begin
               rdat_d[adc_pwr_pkg::ST_VALID +: 4] = valid_q;
               rdat_d[adc_pwr_pkg::ST_STOP] = stop_q;
               rdat_d[adc_pwr_pkg::ST_AWAKE] = (ps_q == adc_pwr_pkg::PS_RUN);
            end
            default:
            begin
            end
         endcase
      end
      ref_int_d = !ref_ext_d;
      cm_oe_n_d = ref_ext_d;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         chip_power_down_bit_q <= 1'b0;
         ref_ext_q <= 1'b0;
         channel_standby_bits_q <= 4'h0;
         fine_q <= adc_pwr_pkg::FINE_RST;
         coarse_q <= 1'b0;
         clkg_q <= adc_pwr_pkg::CLKG_RST;
         ack_q <= 1'b0;
         rdat_q <= 32'h0;
         ref_int_q <= 1'b1;
         cm_oe_n_q <= 1'b0;
      end
      else
      begin
         chip_power_down_bit_q <= chip_power_down_bit_d;
         ref_ext_q <= ref_ext_d;
         channel_standby_bits_q <= channel_standby_bits_d;
         fine_q <= fine_d;
         coarse_q <= coarse_d;
         clkg_q <= clkg_d;
         ack_q <= ack_d;
         rdat_q <= rdat_d;
         ref_int_q <= ref_int_d;
         cm_oe_n_q <= cm_oe_n_d;
      end
   end

   // clock stop detect, power sequencing and channel wake
   always_comb
   begin
      samp_sync_d = {samp_sync_q[1:0], samp_clk_i};
      stop_cnt_d = stop_cnt_q;
      stop_d = stop_q;
      if (samp_sync_q[2] != samp_sync_q[1])
      begin
         stop_cnt_d = 8'h0;
      end
      else if (stop_cnt_q != STOP_MAX)
      begin
         stop_cnt_d = stop_cnt_q + 8'h1;
      end
      // slow sample clock or low swing at default buffer gain
      stop_d = (stop_cnt_q == STOP_MAX) || amp_low;
      ps_d = ps_q;
      wake_d = wake_q;
      case (ps_q)
         adc_pwr_pkg::PS_OFF:
         begin
            wake_d = 32'h0;
            if (!chip_power_down_bit_q && !stop_q)
            begin
               ps_d = adc_pwr_pkg::PS_WAKE;
            end
         end
         adc_pwr_pkg::PS_WAKE:
         begin
            wake_d = wake_q + 32'h1;
            if (chip_power_down_bit_q || stop_q)
            begin
               ps_d = adc_pwr_pkg::PS_OFF;
            end
            else if (wake_q >= WAKE_MAX - 32'h1)
            begin
               ps_d = adc_pwr_pkg::PS_RUN;
            end
         end
         adc_pwr_pkg::PS_RUN:
         begin
            if (chip_power_down_bit_q || stop_q)
            begin
               ps_d = adc_pwr_pkg::PS_OFF;
            end
         end
         default:
         begin
            ps_d = adc_pwr_pkg::PS_OFF;
         end
      endcase
      pwr_d = !chip_power_down_bit_q;
      lvds_d = !chip_power_down_bit_q && !stop_q;
      oe_n_d = !lvds_d;
      for (int i = 0; i < N; i++)
      begin
         conv_d[i] = lvds_d && !channel_standby_bits_q[i];
         stby_cnt_d[i] = stby_cnt_q[i];
         if (!conv_q[i] || ps_q != adc_pwr_pkg::PS_RUN)
         begin
            stby_cnt_d[i] = 8'h0;
         end
         else if (stby_cnt_q[i] != STBY_MAX)
         begin
            stby_cnt_d[i] = stby_cnt_q[i] + 8'h1;
         end
         // after a global wake the channel counter is skipped
         valid_d[i] = conv_q[i] && ps_q == adc_pwr_pkg::PS_RUN &&
                      (stby_cnt_q[i] == STBY_MAX || valid_q[i]);
      end
      if (ps_q == adc_pwr_pkg::PS_WAKE && ps_d == adc_pwr_pkg::PS_RUN)
      begin
         for (int i = 0; i < N; i++)
         begin
            valid_d[i] = conv_q[i];
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         samp_sync_q <= 3'h0;
         stop_cnt_q <= 8'h0;
         stop_q <= 1'b0;
         ps_q <= adc_pwr_pkg::PS_OFF;
         wake_q <= 32'h0;
         valid_q <= 4'h0;
         conv_q <= 4'h0;
         pwr_q <= 1'b0;
         lvds_q <= 1'b0;
         oe_n_q <= 1'b1;
         for (int i = 0; i < N; i++)
         begin
            stby_cnt_q[i] <= 8'h0;
         end
      end
      else
      begin
         samp_sync_q <= samp_sync_d;
         stop_cnt_q <= stop_cnt_d;
         stop_q <= stop_d;
         ps_q <= ps_d;
         wake_q <= wake_d;
         valid_q <= valid_d;
         conv_q <= conv_d;
         pwr_q <= pwr_d;
         lvds_q <= lvds_d;
         oe_n_q <= oe_n_d;
         stby_cnt_q <= stby_cnt_d;
      end
   end

   assign dat_o = rdat_q;
   assign ack_o = ack_q;
   assign conv_pwr_o = conv_q;
   assign ref_pwr_o = pwr_q;
   assign pll_pwr_o = pwr_q;
   assign lvds_pwr_o = lvds_q;
   assign lvds_oe_n_o = oe_n_q;
   assign data_valid_o = valid_q;
   assign ref_internal_o = ref_int_q;
   assign cm_pin_oe_n_o = cm_oe_n_q;
   assign fine_gain_o = fine_q;
   assign coarse_gain_o = coarse_q;
   assign clock_buffer_gain_field_o = clkg_q;

   a_pdn_hiz: assert property (@(posedge clk_i) disable iff (rst_i)
      chip_power_down_bit_q |=> lvds_oe_n_o && !ref_pwr_o && !pll_pwr_o)
      else $error("outputs not off in power down");
   a_pdn_conv: assert property (@(posedge clk_i) disable iff (rst_i)
      chip_power_down_bit_q |=> conv_pwr_o == 4'h0)
      else $error("converters on in power down");
   a_wake_early: assert property (@(posedge clk_i) disable iff (rst_i)
      ps_q == adc_pwr_pkg::PS_WAKE |-> valid_q == 4'h0)
      else $error("data valid during wake");
   a_stop_lvds: assert property (@(posedge clk_i) disable iff (rst_i)
      stop_q |=> !lvds_pwr_o && conv_pwr_o == 4'h0)
      else $error("lvds on in clock stop");
   a_stby_lvds: assert property (@(posedge clk_i) disable iff (rst_i)
      channel_standby_bits_q[0] && !chip_power_down_bit_q && !stop_q
      |=> !conv_pwr_o[0] && lvds_pwr_o)
      else $error("standby wrong");
   a_stby_valid: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(valid_q[0]) && $past(ps_q) == adc_pwr_pkg::PS_RUN |->
      stby_cnt_q[0] == STBY_MAX)
      else $error("channel valid too early");
   a_fine_range: assert property (@(posedge clk_i) disable iff (rst_i)
      fine_q <= adc_pwr_pkg::FINE_MAX)
      else $error("fine gain out of range");
   a_clkg_range: assert property (@(posedge clk_i) disable iff (rst_i)
      clkg_q <= adc_pwr_pkg::CLKG_MAX)
      else $error("clock gain out of range");
   a_gain_reset: assert property (@(posedge clk_i)
      $fell(rst_i) |-> fine_q == 3'h0 && !coarse_q && clkg_q == 3'h1)
      else $error("gain reset values wrong");
   a_ref_pin: assert property (@(posedge clk_i) disable iff (rst_i)
      ref_internal_o != cm_pin_oe_n_o && ref_internal_o != ref_ext_q)
      else $error("reference pin mode wrong");
endmodule

// ### adc_power_and_gain_control_tb.sv
`timescale 1ns/10ps
module adc_power_and_gain_control_tb;
   localparam int unsigned WK = 20;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [31:0] adr_i = 32'h0;
   logic [31:0] dat_i = 32'h0;
   logic [31:0] dat_o;
   logic [31:0] rd;
   logic we_i = 1'b0;
   logic cyc_i = 1'b0;
   logic stb_i = 1'b0;
   logic ack_o;
   logic samp_clk_i = 1'b0;
   logic run = 1'b1;
   logic [3:0] sel_i = 4'hf;
   logic [3:0] conv_pwr_o;
   logic [3:0] data_valid_o;
   logic [15:0] clk_amp_mv_i = 16'h03e8;
   logic ref_pwr_o, pll_pwr_o, lvds_pwr_o, lvds_oe_n_o;
   logic ref_internal_o, cm_pin_oe_n_o, coarse_gain_o;
   logic [2:0] fine_gain_o, clock_buffer_gain_field_o, e;
   logic [11:0] pw;
   int failures = 0;
   int n_checks = 0;
   int n;
   assign pw = {conv_pwr_o, ref_pwr_o, pll_pwr_o, lvds_pwr_o, lvds_oe_n_o,
      data_valid_o};
   always #20 clk_i = ~clk_i;
   // sampling clock stands still while run is low
   always @(posedge clk_i)
      if (run)
         samp_clk_i <= ~samp_clk_i;
   adc_power_and_gain_control #(.WAKE_CYCLES(WK)) dut_u (.clk_i(clk_i),
      .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o),
      .we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i),
      .ack_o(ack_o), .samp_clk_i(samp_clk_i), .clk_amp_mv_i(clk_amp_mv_i),
      .conv_pwr_o(conv_pwr_o), .ref_pwr_o(ref_pwr_o), .pll_pwr_o(pll_pwr_o),
      .lvds_pwr_o(lvds_pwr_o), .lvds_oe_n_o(lvds_oe_n_o),
      .data_valid_o(data_valid_o), .ref_internal_o(ref_internal_o),
      .cm_pin_oe_n_o(cm_pin_oe_n_o), .fine_gain_o(fine_gain_o),
      .coarse_gain_o(coarse_gain_o),
      .clock_buffer_gain_field_o(clock_buffer_gain_field_o));
   task print_verdict();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   // one classic cycle; held until ack is sampled high
   task wb(input logic [3:0] a, input logic w, input logic [31:0] d);
      int i;
      adr_i <= {28'h0, a};
      we_i <= w;
      dat_i <= d;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      i = 0;
      do
      begin
         @(posedge clk_i);
         i++;
      end
      while (ack_o !== 1'b1 && i < 50);
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      if (i >= 50)
      begin
         failures++;
         print_verdict();
      end
      @(posedge clk_i);
   endtask
   task wait_valid(input logic [3:0] m, input int lim);
      n = 0;
      while (data_valid_o !== m && n < lim)
      begin
         @(posedge clk_i);
         n++;
      end
      if (n >= lim)
      begin
         failures++;
         print_verdict();
      end
   endtask
   task t_reset();
      chk({25'h0, fine_gain_o, coarse_gain_o, clock_buffer_gain_field_o},
         32'h1);
      wb(adc_pwr_pkg::ADR_GAIN, 1'b0, 32'h0);
      chk(rd, 32'h100);
      wait_valid(4'hf, WK + 20);
      chk({20'h0, pw}, 32'hfef);
      wb(adc_pwr_pkg::ADR_STAT, 1'b0, 32'h0);
      chk(rd, 32'h2f);
      wb(4'hc, 1'b0, 32'h0);
      chk(rd, 32'h0);
      $display("reset test done");
   endtask
   task t_global();
      wb(adc_pwr_pkg::ADR_CTRL, 1'b1, 32'hf1);
      repeat (3) @(posedge clk_i);
      chk({20'h0, pw}, 32'h010);
      wb(adc_pwr_pkg::ADR_CTRL, 1'b1, 32'h0);
      wait_valid(4'hf, WK + 20);
      chk(32'(n >= WK - 3), 32'h1);
      chk({20'h0, pw}, 32'hfef);
      $display("global power-down test done");
   endtask
   task t_standby();
      wb(adc_pwr_pkg::ADR_CTRL, 1'b1, 32'h50);
      repeat (3) @(posedge clk_i);
      chk({20'h0, pw}, 32'haea);
      wb(adc_pwr_pkg::ADR_CTRL, 1'b1, 32'h0);
      wait_valid(4'hf, 230);
      chk(32'(n >= 195), 32'h1);
      sel_i <= 4'h2;
      wb(adc_pwr_pkg::ADR_CTRL, 1'b1, 32'h1);
      sel_i <= 4'hf;
      repeat (3) @(posedge clk_i);
      chk({20'h0, pw}, 32'hfef);
      $display("standby test done");
   endtask
   task t_stop();
      run <= 1'b0;
      repeat (40) @(posedge clk_i);
      chk({23'h0, conv_pwr_o, lvds_pwr_o, data_valid_o}, 32'h0);
      wb(adc_pwr_pkg::ADR_STAT, 1'b0, 32'h0);
      chk(rd & 32'h10, 32'h10);
      run <= 1'b1;
      wait_valid(4'hf, WK + 40);
      chk(32'(n >= WK - 3), 32'h1);
      clk_amp_mv_i <= 16'h012c;
      repeat (10) @(posedge clk_i);
      chk({23'h0, conv_pwr_o, lvds_pwr_o, data_valid_o}, 32'h0);
      wb(adc_pwr_pkg::ADR_GAIN, 1'b1, 32'h200);
      wait_valid(4'hf, WK + 40);
      chk(32'(n >= WK - 3), 32'h1);
      clk_amp_mv_i <= 16'h03e8;
      $display("clock stop test done");
   endtask
   task t_gain_ref();
      for (int v = 0; v < 8; v++)
      begin
         wb(adc_pwr_pkg::ADR_GAIN, 1'b1, 32'(v) | 32'(v << 8) | 32'(v << 4));
         repeat (2) @(posedge clk_i);
         e = (v > 4) ? 3'h4 : 3'(v);
         chk({29'h0, fine_gain_o}, (v > 6) ? 32'h6 : 32'(v));
         chk({31'h0, coarse_gain_o}, 32'(v & 1));
         chk({29'h0, clock_buffer_gain_field_o}, {29'h0, e});
      end
      wb(adc_pwr_pkg::ADR_GAIN, 1'b1, 32'h100);
      wb(adc_pwr_pkg::ADR_CTRL, 1'b1, 32'h2);
      repeat (2) @(posedge clk_i);
      chk({30'h0, ref_internal_o, cm_pin_oe_n_o}, 32'h1);
      wb(adc_pwr_pkg::ADR_CTRL, 1'b1, 32'h0);
      repeat (2) @(posedge clk_i);
      chk({30'h0, ref_internal_o, cm_pin_oe_n_o}, 32'h2);
      $display("gain and reference test done");
   endtask
   initial
   begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_reset();
      t_global();
      t_standby();
      t_stop();
      t_gain_ref();
      print_verdict();
   end
endmodule
